// ### hdl/cbd_pkg.sv
// constants, register map and helpers for the cell balance driver control
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus
package cbd_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] CBD_IDX_CFG_FIRST = 6'h0c;
    localparam logic [5:0] CBD_IDX_CFG_LAST = 6'h19;
    localparam logic [5:0] CBD_IDX_OPEN = 6'h1a;
    localparam logic [5:0] CBD_IDX_SHORT = 6'h1b;
    localparam logic [5:0] CBD_IDX_STATE = 6'h1c;
    localparam logic [5:0] CBD_IDX_CTRL = 6'h30;
    localparam logic [5:0] CBD_IDX_IRQ_STAT = 6'h31;
    localparam logic [5:0] CBD_IDX_IRQ_MASK = 6'h32;
    localparam int CBD_ADDR_W = 8;
    // field positions
    localparam int CBD_CFG_EN_BIT = 9;
    localparam int CBD_DUR_W = 9;
    localparam int CBD_CTRL_DRV_EN_BIT = 0;
    localparam int CBD_CTRL_ALL_OFF_BIT = 1;
    localparam int CBD_EV_OPEN = 0;
    localparam int CBD_EV_SHORT = 1;
    localparam int CBD_EV_DONE = 2;
    localparam int CBD_EV_W = 3;
    // values after reset
    localparam logic [15:0] CBD_RST_REG = 16'h0000;
    localparam logic [1:0] CBD_RST_CTRL = 2'h0;
    // timing
    localparam int CBD_CLK_PERIOD_NS = 10;
    localparam int CBD_NS_PER_SECOND = 1000000000;
    localparam int CBD_SEC_CYCLES = CBD_NS_PER_SECOND / CBD_CLK_PERIOD_NS;
    localparam int CBD_HALF_MINUTE_S = 30;
    localparam int CBD_SECONDS_PER_MINUTE = 60;
    localparam int CBD_SEC_W = 15;
    // axi responses
    localparam logic [1:0] CBD_RESP_OKAY = 2'h0;
    localparam logic [1:0] CBD_RESP_SLVERR = 2'h2;

    // true for every index that the register file answers
    function automatic logic cbd_mapped(input logic [5:0] idx);
        cbd_mapped = (idx >= CBD_IDX_CFG_FIRST && idx <= CBD_IDX_STATE) ||
                     (idx >= CBD_IDX_CTRL && idx <= CBD_IDX_IRQ_MASK);
    endfunction

    // balancing time in seconds for a duration code
    function automatic logic [CBD_SEC_W-1:0] cbd_limit_s(input logic [CBD_DUR_W-1:0] dur);
        if (dur == '0)
            cbd_limit_s = CBD_SEC_W'(CBD_HALF_MINUTE_S);
        else
            cbd_limit_s = CBD_SEC_W'(dur) * CBD_SEC_W'(CBD_SECONDS_PER_MINUTE);
    endfunction
endpackage

// ### hdl/cbd_chan_if.sv
// command and status signals between the register file and one channel timer
// assumes both ends sit in the same clock domain
`timescale 1ns/10ps
interface cbd_chan_if;
    logic start;
    logic stop;
    logic [cbd_pkg::CBD_DUR_W-1:0] dur;
    logic running;
    logic expired;
    modport ctrl (output start, output stop, output dur, input running, input expired);
    modport timer (input start, input stop, input dur, output running, output expired);
endinterface

// ### hdl/cbd_chan_timer.sv
// one balancing channel: on/off state and its duration timer
// assumes start and stop are one-cycle pulses from the register file
`timescale 1ns/10ps
module cbd_chan_timer #(
    parameter int SEC_CYCLES = cbd_pkg::CBD_SEC_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // control from the register file
    cbd_chan_if.timer ch
);
    import cbd_pkg::*;
    localparam int CW = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;

    logic running_q;
    logic expired_q;
    logic [CW-1:0] cyc_q;
    logic [CBD_SEC_W-1:0] sec_q;
    logic tick;
    logic done;

    assign tick = (cyc_q == CW'(SEC_CYCLES - 1));
    // compare with >= so a shortened duration mid-run still ends the run
    assign done = running_q && tick && ((sec_q + 1'b1) >= cbd_limit_s(ch.dur));

    // state and counters; stop beats start so a short wins while the all-off option is clear
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            running_q <= 1'b0;
            expired_q <= 1'b0;
            cyc_q <= '0;
            sec_q <= '0;
        end
        else
        begin
            expired_q <= 1'b0;
            if (ch.stop)
                running_q <= 1'b0;
            else if (ch.start)
            begin
                running_q <= 1'b1;
                cyc_q <= '0;
                sec_q <= '0;
            end
            else if (done)
            begin
                running_q <= 1'b0;
                expired_q <= 1'b1;
            end
            else if (running_q)
            begin
                cyc_q <= tick ? '0 : cyc_q + 1'b1;
                sec_q <= tick ? sec_q + 1'b1 : sec_q;
            end
        end
    end

    assign ch.running = running_q;
    assign ch.expired = expired_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_start_restarts: assert property (ch.start && !ch.stop |=> running_q && sec_q == '0 && cyc_q == '0)
        else $error("start did not restart the timer");
    a_expire_at_limit: assert property (expired_q |-> !running_q && $past(sec_q) + 1'b1 >= $past(cbd_limit_s(ch.dur)))
        else $error("channel expired before its limit");
    c_expire: cover property (expired_q);
endmodule

// ### hdl/cbd_balance_ctrl.sv
// register file and fault handling for the passive cell balancing drivers
// assumes an AXI4-Lite master on the same clock and fault detectors
// that pulse or hold their detect lines synchronous to clock_i
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module cbd_balance_ctrl #(
    parameter int NUM_CH = 6,
    parameter int SEC_CYCLES = cbd_pkg::CBD_SEC_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // axi4-lite write channels
    input wire logic [cbd_pkg::CBD_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read channels
    input wire logic [cbd_pkg::CBD_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // fault detectors
    input wire logic [NUM_CH-1:0] open_load_detect_i,
    input wire logic [NUM_CH-1:0] short_detect_i,
    // drivers and interrupt
    output logic [NUM_CH-1:0] balance_driver_on_o,
    output logic irq_o
);
    import cbd_pkg::*;

    logic awready_q, wready_q, aw_full_q, w_full_q, bvalid_q;
    logic [1:0] bresp_q;
    logic [5:0] aw_idx_q;
    logic [15:0] wdata_q;
    logic [15:0] wmask_q;
    logic arready_q, rvalid_q;
    logic [1:0] rresp_q;
    logic [15:0] rdata_q;
    logic wr_en;
    logic [5:0] ar_idx;
    logic [15:0] rd_word;
    logic [CBD_DUR_W-1:0] dur_q [NUM_CH];
    logic [NUM_CH-1:0] open_flags_q, short_flags_q, on_q;
    logic [NUM_CH-1:0] clr_open, clr_short, kill, start_vec, stop_vec, run_vec, exp_vec;
    logic drv_en_q, all_off_q;
    logic [CBD_EV_W-1:0] irq_stat_q, irq_mask_q, ev_set, ev_clr;
    logic irq_q;

    // write address and data are taken independently, executed together
    assign wr_en = aw_full_q && w_full_q && !bvalid_q;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            awready_q <= 1'b1;
            aw_full_q <= 1'b0;
            aw_idx_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid_i && awready_q)
            begin
                awready_q <= 1'b0;
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr_i[7:2];
            end
            if (wr_en)
                aw_full_q <= 1'b0;
            if (bvalid_q && s_axi_bready_i)
                awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wready_q <= 1'b1;
            w_full_q <= 1'b0;
            wdata_q <= '0;
            wmask_q <= '0;
        end
        else
        begin
            if (s_axi_wvalid_i && wready_q)
            begin
                wready_q <= 1'b0;
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata_i[15:0];
                wmask_q <= {{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
            end
            if (wr_en)
                w_full_q <= 1'b0;
            if (bvalid_q && s_axi_bready_i)
                wready_q <= 1'b1;
        end
    end

    // write response; unmapped offsets answer slverr and change nothing
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= CBD_RESP_OKAY;
        end
        else if (wr_en)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= cbd_mapped(aw_idx_q) ? CBD_RESP_OKAY : CBD_RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready_i)
            bvalid_q <= 1'b0;
    end

    // per-channel commands; with the all-off option clear, a short in the same cycle overrides a start
    always_comb
    begin
        kill = all_off_q ? '0 : short_detect_i;
        for (int i = 0; i < NUM_CH; i++)
        begin
            start_vec[i] = 1'b0;
            stop_vec[i] = kill[i];
            if (wr_en && wmask_q[CBD_CFG_EN_BIT] && aw_idx_q == CBD_IDX_CFG_FIRST + 6'(i))
            begin
                start_vec[i] = wdata_q[CBD_CFG_EN_BIT] && !kill[i];
                stop_vec[i] = kill[i] || !wdata_q[CBD_CFG_EN_BIT];
            end
        end
    end

    // duration fields, byte lanes honoured
    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (sys_rst_i)
                dur_q[i] <= CBD_RST_REG[CBD_DUR_W-1:0];
            else if (wr_en && aw_idx_q == CBD_IDX_CFG_FIRST + 6'(i))
                dur_q[i] <= (wdata_q[CBD_DUR_W-1:0] & wmask_q[CBD_DUR_W-1:0]) |
                            (dur_q[i] & ~wmask_q[CBD_DUR_W-1:0]);
        end
    end

    // channel timers
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        cbd_chan_if ch_if();
        assign ch_if.start = start_vec[g];
        assign ch_if.stop = stop_vec[g];
        assign ch_if.dur = dur_q[g];
        assign run_vec[g] = ch_if.running;
        assign exp_vec[g] = ch_if.expired;
        cbd_chan_timer #(.SEC_CYCLES(SEC_CYCLES)) u_timer (
            .clock_i(clock_i),
            .sys_rst_i(sys_rst_i),
            .ch(ch_if)
        );
    end

    // fault flags: write zero clears, unstrobed lanes keep, a new detect wins
    assign clr_open = (wr_en && aw_idx_q == CBD_IDX_OPEN) ?
                      (~wdata_q[NUM_CH-1:0] & wmask_q[NUM_CH-1:0]) : '0;
    assign clr_short = (wr_en && aw_idx_q == CBD_IDX_SHORT) ?
                       (~wdata_q[NUM_CH-1:0] & wmask_q[NUM_CH-1:0]) : '0;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            open_flags_q <= '0;
            short_flags_q <= '0;
        end
        else
        begin
            open_flags_q <= (open_flags_q & ~clr_open) | open_load_detect_i;
            short_flags_q <= (short_flags_q & ~clr_short) | short_detect_i;
        end
    end

    // global drive enable and the all-off option
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            drv_en_q <= CBD_RST_CTRL[CBD_CTRL_DRV_EN_BIT];
            all_off_q <= CBD_RST_CTRL[CBD_CTRL_ALL_OFF_BIT];
        end
        else
        begin
            if (wr_en && aw_idx_q == CBD_IDX_CTRL && wmask_q[0])
            begin
                drv_en_q <= wdata_q[CBD_CTRL_DRV_EN_BIT];
                all_off_q <= wdata_q[CBD_CTRL_ALL_OFF_BIT];
            end
            // safety first: with the all-off option set, a short beats a software enable in the same cycle
            if (all_off_q && |short_detect_i)
                drv_en_q <= 1'b0;
        end
    end

    // driver outputs are registered so they never glitch on decode
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            on_q <= '0;
        else
            on_q <= run_vec & {NUM_CH{drv_en_q}};
    end

    // interrupt status: write one clears, a new event wins
    assign ev_set = {|exp_vec, |short_detect_i, |open_load_detect_i};
    assign ev_clr = (wr_en && aw_idx_q == CBD_IDX_IRQ_STAT) ?
                    (wdata_q[CBD_EV_W-1:0] & wmask_q[CBD_EV_W-1:0]) : '0;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
            if (wr_en && aw_idx_q == CBD_IDX_IRQ_MASK && wmask_q[0])
                irq_mask_q <= wdata_q[CBD_EV_W-1:0];
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read decode; channels beyond NUM_CH in the config range read zero
    assign ar_idx = s_axi_araddr_i[7:2];
    always_comb
    begin
        rd_word = CBD_RST_REG;
        if (ar_idx >= CBD_IDX_CFG_FIRST && ar_idx <= CBD_IDX_CFG_LAST)
        begin
            for (int i = 0; i < NUM_CH; i++)
                if (ar_idx == CBD_IDX_CFG_FIRST + 6'(i))
                    rd_word = {6'h00, on_q[i], dur_q[i]};
        end
        else
        begin
            case (ar_idx)
                CBD_IDX_OPEN: rd_word[NUM_CH-1:0] = open_flags_q;
                CBD_IDX_SHORT: rd_word[NUM_CH-1:0] = short_flags_q;
                CBD_IDX_STATE: rd_word[NUM_CH-1:0] = on_q;
                CBD_IDX_CTRL: rd_word[1:0] = {all_off_q, drv_en_q};
                CBD_IDX_IRQ_STAT: rd_word[CBD_EV_W-1:0] = irq_stat_q;
                CBD_IDX_IRQ_MASK: rd_word[CBD_EV_W-1:0] = irq_mask_q;
                default: rd_word = CBD_RST_REG;
            endcase
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= CBD_RESP_OKAY;
        end
        else if (s_axi_arvalid_i && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= cbd_mapped(ar_idx) ? CBD_RESP_OKAY : CBD_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready_i)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = {16'h0000, rdata_q};
    assign balance_driver_on_o = on_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_open_flag_set: assert property (|open_load_detect_i |=> (open_flags_q & $past(open_load_detect_i)) == $past(open_load_detect_i))
        else $error("open-load detect not latched");
    a_short_flag_set: assert property (|short_detect_i |=> (short_flags_q & $past(short_detect_i)) == $past(short_detect_i))
        else $error("short detect not latched");
    a_w0c_clears: assert property (wr_en && aw_idx_q == CBD_IDX_SHORT && wmask_q[0] && !wdata_q[0] && !short_detect_i[0] |=> !short_flags_q[0])
        else $error("write zero did not clear short flag");
    a_w1_keeps: assert property (wr_en && aw_idx_q == CBD_IDX_OPEN && wdata_q[0] && open_flags_q[0] |=> open_flags_q[0])
        else $error("write one cleared open flag");
    a_short_local_off: assert property (!all_off_q && short_detect_i[0] |=> !run_vec[0] ##1 !balance_driver_on_o[0])
        else $error("shorted driver stayed on");
    a_short_others_run: assert property (!all_off_q && short_detect_i[0] && !short_detect_i[1] && run_vec[1] && !stop_vec[1] && !exp_vec[1] |=> drv_en_q == $past(drv_en_q) || $past(wr_en))
        else $error("global enable dropped without option");
    a_short_all_off: assert property (all_off_q && |short_detect_i |=> !drv_en_q ##1 balance_driver_on_o == '0)
        else $error("all-off option did not stop drivers");
    a_cfg_readback: assert property (s_axi_arvalid_i && arready_q && ar_idx == CBD_IDX_CFG_FIRST |=> s_axi_rvalid_o && s_axi_rdata_o[CBD_DUR_W-1:0] == $past(dur_q[0]))
        else $error("config readback mismatch");
    a_enable_write_starts: assert property (wr_en && start_vec[0] |=> run_vec[0])
        else $error("enable write did not start channel");

    c_short_all_off: cover property (all_off_q && drv_en_q && |short_detect_i);
    c_flag_clear: cover property (wr_en && aw_idx_q == CBD_IDX_OPEN && |clr_open);
    c_irq: cover property ($rose(irq_o));
    c_restart: cover property (start_vec[0] && run_vec[0]);
endmodule

// ### bench/testbench.sv
// self-checking bench for the cell balance driver control register block
// assumes one AXI4-Lite master (this bench) and a shortened second count
`timescale 1ns/10ps
module testbench;
    import cbd_pkg::*;

    // four cycles a second keeps a half-minute code at 120 cycles
    localparam int SEC = 4;

    // clock, reset and bus signals
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [5:0] open_det = 6'h00;
    logic [5:0] short_det = 6'h00;
    logic [5:0] drv_on;
    logic irq;
    int err_total = 0;
    int samples_checked = 0;

    always #5 clock_i = ~clock_i;

    cbd_balance_ctrl #(.NUM_CH(6), .SEC_CYCLES(SEC)) cbd_balance_ctrl_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .open_load_detect_i(open_det), .short_detect_i(short_det),
        .balance_driver_on_o(drv_on), .irq_o(irq)
    );

    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [5:0] cfg(input int ch);
        return CBD_IDX_CFG_FIRST + 6'(ch);
    endfunction

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clock_i);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (bvalid && aw_ok && w_ok)
                break;
            if (awvalid && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (1'b1); // only the watchdog ends a hung wait
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask

    // read and compare the whole data word, upper half expected zero, and the response
    task automatic rd_chk(input logic [5:0] idx, input logic [15:0] e, input logic [1:0] er);
        logic ar_ok;
        ar_ok = 1'b0;
        @(posedge clock_i);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            if (rvalid && ar_ok)
                break;
            if (arvalid && arready)
            begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end while (1'b1); // only the watchdog ends a hung wait
        rready <= 1'b0;
        chk(rdata, {16'h0000, e}, "read data");
        chk({30'h0, rresp}, {30'h0, er}, "read response");
    endtask

    // one-cycle detector pulse
    task automatic pulse(input logic [5:0] o, input logic [5:0] s);
        @(posedge clock_i);
        open_det <= o;
        short_det <= s;
        @(posedge clock_i);
        open_det <= 6'h00;
        short_det <= 6'h00;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog: whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock_i);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // values after reset and the unmapped hole
        rd_chk(cfg(0), 16'h0000, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_OPEN, 16'h0000, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_SHORT, 16'h0000, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_STATE, 16'h0000, CBD_RESP_OKAY);
        rd_chk(6'h20, 16'h0000, CBD_RESP_SLVERR);
        wr(6'h20, 16'hffff, CBD_RESP_SLVERR);
        // duration field on the last live channel; first dead one reads zero
        wr(cfg(5), 16'h01ff, CBD_RESP_OKAY);
        rd_chk(cfg(5), 16'h01ff, CBD_RESP_OKAY);
        wr(cfg(6), 16'h01ff, CBD_RESP_OKAY);
        rd_chk(cfg(6), 16'h0000, CBD_RESP_OKAY);
        wr(cfg(5), 16'h0000, CBD_RESP_OKAY);
        // global enable on, only the expiry event unmasked
        wr(CBD_IDX_CTRL, 16'h0001, CBD_RESP_OKAY);
        wr(CBD_IDX_IRQ_STAT, 16'h0007, CBD_RESP_OKAY);
        wr(CBD_IDX_IRQ_MASK, 16'h0004, CBD_RESP_OKAY);
        // half-minute run, restarted part way so it outlives the first limit
        wr(cfg(0), 16'h0200, CBD_RESP_OKAY);
        repeat (5) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h01, "driver on after start");
        rd_chk(cfg(0), 16'h0200, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_STATE, 16'h0001, CBD_RESP_OKAY);
        repeat (80) @(posedge clock_i);
        wr(cfg(0), 16'h0200, CBD_RESP_OKAY);
        repeat (80) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h01, "restart keeps driver on");
        repeat (60) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h00, "driver off after half minute");
        chk({31'h0, irq}, 32'h1, "expiry interrupt");
        rd_chk(CBD_IDX_IRQ_STAT, 16'h0004, CBD_RESP_OKAY);
        wr(CBD_IDX_IRQ_MASK, 16'h0000, CBD_RESP_OKAY);
        repeat (3) @(posedge clock_i);
        chk({31'h0, irq}, 32'h0, "masked interrupt");
        wr(CBD_IDX_IRQ_MASK, 16'h0004, CBD_RESP_OKAY);
        wr(CBD_IDX_IRQ_STAT, 16'h0004, CBD_RESP_OKAY);
        repeat (3) @(posedge clock_i);
        chk({31'h0, irq}, 32'h0, "cleared interrupt");
        // option clear: a short on one driver leaves the other running
        wr(cfg(0), 16'h0201, CBD_RESP_OKAY);
        wr(cfg(1), 16'h0201, CBD_RESP_OKAY);
        pulse(6'h00, 6'h02);
        repeat (4) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h01, "only shorted driver off");
        rd_chk(CBD_IDX_SHORT, 16'h0002, CBD_RESP_OKAY);
        wr(CBD_IDX_SHORT, 16'h003f, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_SHORT, 16'h0002, CBD_RESP_OKAY);
        wr(CBD_IDX_SHORT, 16'h0000, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_SHORT, 16'h0000, CBD_RESP_OKAY);
        // open-load flags, cleared one at a time
        pulse(6'h24, 6'h00);
        rd_chk(CBD_IDX_OPEN, 16'h0024, CBD_RESP_OKAY);
        wr(CBD_IDX_OPEN, 16'h0020, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_OPEN, 16'h0020, CBD_RESP_OKAY);
        wr(CBD_IDX_OPEN, 16'h0000, CBD_RESP_OKAY);
        rd_chk(CBD_IDX_OPEN, 16'h0000, CBD_RESP_OKAY);
        // option set: one short drops the global enable and every driver
        wr(CBD_IDX_CTRL, 16'h0003, CBD_RESP_OKAY);
        wr(cfg(1), 16'h0201, CBD_RESP_OKAY);
        repeat (3) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h03, "both drivers on");
        pulse(6'h00, 6'h01);
        repeat (4) @(posedge clock_i);
        chk({26'h0, drv_on}, 32'h00, "all drivers off");
        rd_chk(CBD_IDX_CTRL, 16'h0002, CBD_RESP_OKAY);
        wr(cfg(0), 16'h0000, CBD_RESP_OKAY);
        wr(cfg(1), 16'h0000, CBD_RESP_OKAY);
        print_verdict();
    end
endmodule
